// file: src/sia_regs.svh
// Purpose: register offsets, field positions and reset values of the status block
// Assumes: byte offsets on a 16-bit register port
// Notes: definitions only
`ifndef SIA_REGS_SVH
`define SIA_REGS_SVH

`define SIA_ADDR_W 8
`define SIA_DATA_W 16
`define SIA_PORTS 16

// register offsets
`define SIA_OFF_MASTER_STATUS 8'h20
`define SIA_OFF_MASTER_MASK 8'h24
`define SIA_OFF_DMA_STATUS 8'h28
`define SIA_OFF_DMA_MASK 8'h2c
`define SIA_OFF_LB_STATUS 8'h30
`define SIA_OFF_LB_MASK 8'h34

// master status and mask fields
`define SIA_M_RX_ALIGN 0
`define SIA_M_TX_ALIGN 1
`define SIA_M_BIT_TESTER 2
`define SIA_M_PCI_SYS_ERR 3
`define SIA_M_PCI_PAR_ERR 4
`define SIA_M_LB_TIMEOUT 14
`define SIA_M_LB_IRQ 15
`define SIA_MASTER_VALID 16'hc01f

// dma status and mask fields
`define SIA_D_CHECKSUM 2
`define SIA_D_ABORT 3
`define SIA_D_LENGTH 4
`define SIA_D_OVERFLOW 5
`define SIA_D_LARGE_RD 6
`define SIA_D_LARGE_ERR 7
`define SIA_D_SMALL_RD 8
`define SIA_D_SMALL_ERR 9
`define SIA_DMA_STAT_VALID 16'h03fc
`define SIA_DMA_MASK_VALID 16'hfffc

// reset values
`define SIA_RST_STATUS 16'h0000
`define SIA_RST_MASK 16'h0000

`endif

// file: src/sia_pkg.sv
// Purpose: shared types of the status and interrupt block
// Assumes: offsets come from sia_regs.svh
// Notes: none
package sia_pkg;

  typedef logic [15:0] sia_word_t;
  typedef logic [7:0] sia_addr_t;

  // register selected by the current access
  typedef enum logic [2:0] {
    SIA_SEL_NONE = 3'b000,
    SIA_SEL_MSTAT = 3'b001,
    SIA_SEL_MMASK = 3'b010,
    SIA_SEL_DSTAT = 3'b011,
    SIA_SEL_DMASK = 3'b100,
    SIA_SEL_LSTAT = 3'b101,
    SIA_SEL_LMASK = 3'b110
  } sia_sel_t;

endpackage : sia_pkg

// file: src/sia_rc_status.sv
// Purpose: bank of sticky event bits cleared by a host read
// Assumes: event pulses come from logic on the same clock
// Notes: a set in the clearing cycle wins
`timescale 1ns/100ps
module sia_rc_status #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] VALID = '1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // events and host read
  input wire logic [WIDTH-1:0] setPulse,
  input wire logic rdClr,
  // state
  output logic [WIDTH-1:0] status
);
  logic [WIDTH-1:0] status_q;
  logic [WIDTH-1:0] status_d;

  if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
    $error("sia_rc_status: WIDTH must be 1 to 16");
  end

  always_comb begin
    status_d = status_q;
    if (rdClr) begin
      status_d = '0;
    end
    status_d = (status_d | setPulse) & VALID;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  assign status = status_q;

endmodule : sia_rc_status

// file: src/sia_loop_status.sv
// Purpose: per-port loop code detector status bits
// Assumes: detector signals come from logic on the same clock
// Notes: a timed-out port holds its bit until its detector reset bit toggles
`timescale 1ns/100ps
module sia_loop_status #(
  parameter int PORTS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // detector side
  input wire logic [PORTS-1:0] portLoopCodeEvent,
  input wire logic [PORTS-1:0] loopSearchTimeout,
  input wire logic [PORTS-1:0] loopDetectorReset,
  // host read
  input wire logic rdClr,
  // state
  output logic [PORTS-1:0] status
);
  logic [PORTS-1:0] event_q;
  logic [PORTS-1:0] hold_q;
  logic [PORTS-1:0] rstPrev_q;
  logic [PORTS-1:0] rstToggle;

  if (PORTS < 1 || PORTS > 16) begin : g_bad_ports
    $error("sia_loop_status: PORTS must be 1 to 16");
  end

  assign rstToggle = loopDetectorReset ^ rstPrev_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstPrev_q <= '0;
    end else begin
      rstPrev_q <= loopDetectorReset;
    end
  end

  // validated code or first timeout: sticky, read clears, set wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      event_q <= '0;
    end else begin
      event_q <= (rdClr ? '0 : event_q) | portLoopCodeEvent | loopSearchTimeout;
    end
  end

  // timeout holds its bit until the detector reset toggles
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hold_q <= '0;
    end else begin
      hold_q <= (hold_q & ~rstToggle) | loopSearchTimeout;
    end
  end

  assign status = event_q | hold_q;

endmodule : sia_loop_status

// file: src/sia_status_top.sv
// Purpose: status and interrupt registers with interrupt pin drive
// Assumes: 16-bit register port with byte offsets; events are one-cycle pulses
// Notes: read data and both interrupt pins come from flip-flops
`timescale 1ns/100ps
`include "sia_regs.svh"
module sia_status_top #(
  parameter int NUM_PORTS = `SIA_PORTS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire sia_pkg::sia_addr_t regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire sia_pkg::sia_word_t regWrData,
  output sia_pkg::sia_word_t regRdData,
  // master events, one-cycle pulses
  input wire logic rxFrameAlignChange,
  input wire logic txFrameAlignChange,
  input wire logic bitTesterStateChange,
  input wire logic pciSystemError,
  input wire logic pciParityError,
  input wire logic localBusTimeoutError,
  input wire logic localBusIrqSeen,
  // receive dma and hdlc events, one-cycle pulses
  input wire logic rxChecksumError,
  input wire logic rxAbortSeen,
  input wire logic rxLengthViolation,
  input wire logic rxFifoOverflow,
  input wire logic largeFreeQueueRead,
  input wire logic largeFreeQueueEmptyError,
  input wire logic smallFreeQueueRead,
  input wire logic smallFreeQueueEmptyError,
  // loop code detectors, per port
  input wire logic [NUM_PORTS-1:0] portLoopCodeEvent,
  input wire logic [NUM_PORTS-1:0] loopSearchTimeout,
  input wire logic [NUM_PORTS-1:0] loopDetectorReset,
  // local bus mode pin, high in configuration mode
  input wire logic localBusConfigMode,
  // interrupt pins, active low
  output logic pciInterruptPin_n,
  output logic localInterruptPin_n
);
  import sia_pkg::*;

  // ==========================================================
  // parameter check
  if (NUM_PORTS < 1 || NUM_PORTS > `SIA_PORTS) begin : g_bad_ports
    $error("sia_status_top: NUM_PORTS must be 1 to 16");
  end

  // field positions must fit the register word
  if (`SIA_DATA_W != 16) begin : g_bad_word
    $error("sia_status_top: register word must be 16 bits");
  end

  if (`SIA_M_LB_IRQ >= `SIA_DATA_W || `SIA_D_SMALL_ERR >= `SIA_DATA_W) begin : g_bad_fields
    $error("sia_status_top: field position beyond the register word");
  end

  // ==========================================================
  // address decode
  function automatic sia_sel_t decodeAddr(input sia_addr_t addr);
    case (addr)
      `SIA_OFF_MASTER_STATUS: decodeAddr = SIA_SEL_MSTAT;
      `SIA_OFF_MASTER_MASK: decodeAddr = SIA_SEL_MMASK;
      `SIA_OFF_DMA_STATUS: decodeAddr = SIA_SEL_DSTAT;
      `SIA_OFF_DMA_MASK: decodeAddr = SIA_SEL_DMASK;
      `SIA_OFF_LB_STATUS: decodeAddr = SIA_SEL_LSTAT;
      `SIA_OFF_LB_MASK: decodeAddr = SIA_SEL_LMASK;
      default: decodeAddr = SIA_SEL_NONE;
    endcase
  endfunction : decodeAddr

  // any bit set with its mask enabled
  function automatic logic anyUnmasked(input sia_word_t stat, input sia_word_t mask);
    anyUnmasked = |(stat & mask);
  endfunction : anyUnmasked

  sia_sel_t sel;
  logic rdMstat;
  logic rdDstat;
  logic rdLstat;
  logic wrMmask;
  logic wrDmask;
  logic wrLmask;

  assign sel = decodeAddr(regAddr);
  assign rdMstat = regRdEn && (sel == SIA_SEL_MSTAT);
  assign rdDstat = regRdEn && (sel == SIA_SEL_DSTAT);
  assign rdLstat = regRdEn && (sel == SIA_SEL_LSTAT);
  assign wrMmask = regWrEn && (sel == SIA_SEL_MMASK);
  assign wrDmask = regWrEn && (sel == SIA_SEL_DMASK);
  assign wrLmask = regWrEn && (sel == SIA_SEL_LMASK);

  // ==========================================================
  // mode pin synchroniser
  logic cfgMeta_q;
  logic cfgMode_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfgMeta_q <= 1'b0;
      cfgMode_q <= 1'b0;
    end else begin
      cfgMeta_q <= localBusConfigMode;
      cfgMode_q <= cfgMeta_q;
    end
  end

  // ==========================================================
  // mask registers
  sia_word_t masterMask_q;
  sia_word_t dmaMask_q;
  sia_word_t loopMask_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      masterMask_q <= `SIA_RST_MASK;
    end else if (wrMmask) begin
      masterMask_q <= regWrData & `SIA_MASTER_VALID;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dmaMask_q <= `SIA_RST_MASK;
    end else if (wrDmask) begin
      dmaMask_q <= regWrData & `SIA_DMA_MASK_VALID;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      loopMask_q <= `SIA_RST_MASK;
    end else if (wrLmask) begin
      loopMask_q <= regWrData & sia_word_t'({NUM_PORTS{1'b1}});
    end
  end

  // ==========================================================
  // master status
  sia_word_t masterSet;
  sia_word_t masterStat;

  always_comb begin
    masterSet = '0;
    masterSet[`SIA_M_RX_ALIGN] = rxFrameAlignChange;
    masterSet[`SIA_M_TX_ALIGN] = txFrameAlignChange;
    masterSet[`SIA_M_BIT_TESTER] = bitTesterStateChange;
    masterSet[`SIA_M_PCI_SYS_ERR] = pciSystemError;
    masterSet[`SIA_M_PCI_PAR_ERR] = pciParityError;
    masterSet[`SIA_M_LB_TIMEOUT] = localBusTimeoutError;
    masterSet[`SIA_M_LB_IRQ] = localBusIrqSeen;
  end

  sia_rc_status #(
    .WIDTH(16),
    .VALID(`SIA_MASTER_VALID)
  ) u_master_status (
    .core_clk(core_clk),
    .nrst(nrst),
    .setPulse(masterSet),
    .rdClr(rdMstat),
    .status(masterStat)
  );

  // ==========================================================
  // dma status
  sia_word_t dmaSet;
  sia_word_t dmaStat;

  always_comb begin
    dmaSet = '0;
    dmaSet[`SIA_D_CHECKSUM] = rxChecksumError;
    dmaSet[`SIA_D_ABORT] = rxAbortSeen;
    dmaSet[`SIA_D_LENGTH] = rxLengthViolation;
    dmaSet[`SIA_D_OVERFLOW] = rxFifoOverflow;
    dmaSet[`SIA_D_LARGE_RD] = largeFreeQueueRead;
    dmaSet[`SIA_D_LARGE_ERR] = largeFreeQueueEmptyError;
    dmaSet[`SIA_D_SMALL_RD] = smallFreeQueueRead;
    dmaSet[`SIA_D_SMALL_ERR] = smallFreeQueueEmptyError;
  end

  // read clears, a new event sets again
  sia_rc_status #(
    .WIDTH(16),
    .VALID(`SIA_DMA_STAT_VALID)
  ) u_dma_status (
    .core_clk(core_clk),
    .nrst(nrst),
    .setPulse(dmaSet),
    .rdClr(rdDstat),
    .status(dmaStat)
  );

  // ==========================================================
  // loop detector status
  logic [NUM_PORTS-1:0] loopStatPorts;
  sia_word_t loopStat;

  sia_loop_status #(
    .PORTS(NUM_PORTS)
  ) u_loop_status (
    .core_clk(core_clk),
    .nrst(nrst),
    .portLoopCodeEvent(portLoopCodeEvent),
    .loopSearchTimeout(loopSearchTimeout),
    .loopDetectorReset(loopDetectorReset),
    .rdClr(rdLstat),
    .status(loopStatPorts)
  );

  // ports above NUM_PORTS read zero
  assign loopStat = sia_word_t'(loopStatPorts);

  // ==========================================================
  // read data, registered, unmapped reads zero
  sia_word_t rdData_q;
  sia_word_t rdData_d;

  always_comb begin
    case (sel)
      SIA_SEL_MSTAT: rdData_d = masterStat;
      SIA_SEL_MMASK: rdData_d = masterMask_q;
      SIA_SEL_DSTAT: rdData_d = dmaStat;
      SIA_SEL_DMASK: rdData_d = dmaMask_q;
      SIA_SEL_LSTAT: rdData_d = loopStat;
      SIA_SEL_LMASK: rdData_d = loopMask_q;
      default: rdData_d = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdData_q <= '0;
    end else if (regRdEn) begin
      rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;

  // ==========================================================
  // interrupt pins
  sia_word_t masterLocalMask;
  logic pciReq;
  logic localReq;
  logic pciIntN_q;
  logic localIntN_q;

  // local bus irq seen reaches only the pci pin
  always_comb begin
    masterLocalMask = masterMask_q;
    masterLocalMask[`SIA_M_LB_IRQ] = 1'b0;
  end

  // per-source requests
  logic masterPciReq;
  logic masterLocalReq;
  logic loopReq;
  logic dmaReq;

  assign masterPciReq = anyUnmasked(masterStat, masterMask_q);
  assign masterLocalReq = anyUnmasked(masterStat, masterLocalMask);
  assign loopReq = anyUnmasked(loopStat, loopMask_q);
  assign dmaReq = anyUnmasked(dmaStat, dmaMask_q);

  assign pciReq = masterPciReq || loopReq || dmaReq;

  assign localReq = cfgMode_q && (masterLocalReq || loopReq || dmaReq);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pciIntN_q <= 1'b1;
      localIntN_q <= 1'b1;
    end else begin
      pciIntN_q <= ~pciReq;
      localIntN_q <= ~localReq;
    end
  end

  assign pciInterruptPin_n = pciIntN_q;
  assign localInterruptPin_n = localIntN_q;

endmodule : sia_status_top

// file: bench/sia_status_chk_sva.sv
// Purpose: port-level checks of the status block
// Assumes: mask registers mirrored from host writes
// Notes: bound to sia_status_top
`timescale 1ns/100ps
`include "sia_regs.svh"
module sia_status_chk #(
  parameter int NUM_PORTS = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire sia_pkg::sia_addr_t regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire sia_pkg::sia_word_t regWrData,
  input wire sia_pkg::sia_word_t regRdData,
  // dma events
  input wire logic rxChecksumError,
  input wire logic rxAbortSeen,
  input wire logic rxLengthViolation,
  input wire logic rxFifoOverflow,
  input wire logic largeFreeQueueRead,
  input wire logic largeFreeQueueEmptyError,
  input wire logic smallFreeQueueRead,
  input wire logic smallFreeQueueEmptyError,
  // loop events and mode
  input wire logic [NUM_PORTS-1:0] portLoopCodeEvent,
  input wire logic localBusConfigMode,
  // pins
  input wire logic pciInterruptPin_n,
  input wire logic localInterruptPin_n
);
  import sia_pkg::*;
  // =====
  // mask mirrors
  logic [15:0] dMask_q;
  logic [15:0] mMask_q;
  logic [NUM_PORTS-1:0] lMask_q;
  wire logic [15:0] dEv = {6'h00, smallFreeQueueEmptyError, smallFreeQueueRead,
    largeFreeQueueEmptyError, largeFreeQueueRead, rxFifoOverflow, rxLengthViolation,
    rxAbortSeen, rxChecksumError, 2'h0};
  wire logic mapped = regAddr inside {8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dMask_q <= 16'h0000;
      mMask_q <= 16'h0000;
      lMask_q <= '0;
    end else if (regWrEn) begin
      if (regAddr == `SIA_OFF_DMA_MASK) dMask_q <= regWrData & `SIA_DMA_MASK_VALID;
      if (regAddr == `SIA_OFF_MASTER_MASK) mMask_q <= regWrData & `SIA_MASTER_VALID;
      if (regAddr == `SIA_OFF_LB_MASK) lMask_q <= regWrData[NUM_PORTS-1:0];
    end
  end
  // =====
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_DMA_PIN: assert property (!regWrEn && |(dEv & dMask_q) |-> ##2 !pciInterruptPin_n)
    else $error("dma event did not raise pci pin");
  AST_LOOP_PIN: assert property (!regWrEn && |(portLoopCodeEvent & lMask_q) |-> ##2 !pciInterruptPin_n)
    else $error("loop event did not raise pci pin");
  AST_DMA_MASK_RD: assert property (regRdEn && regAddr == `SIA_OFF_DMA_MASK |=> regRdData == $past(dMask_q))
    else $error("dma mask read wrong");
  AST_MST_MASK_RD: assert property (regRdEn && regAddr == `SIA_OFF_MASTER_MASK |=> regRdData == $past(mMask_q))
    else $error("master mask read wrong");
  AST_LOOP_MASK_RD: assert property (regRdEn && regAddr == `SIA_OFF_LB_MASK |=> regRdData == 16'($past(lMask_q)))
    else $error("loop mask read wrong");
  AST_UNMAPPED_RD: assert property (regRdEn && !mapped |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  AST_RD_HOLD: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  AST_LOCAL_OFF: assert property (!localBusConfigMode [*4] |-> localInterruptPin_n)
    else $error("local pin active outside configuration mode");
endmodule : sia_status_chk
bind sia_status_top sia_status_chk #(.NUM_PORTS(NUM_PORTS)) i_chk (.*);

// file: bench/sia_host_model.sv
// Purpose: host side, counts interrupt services
// Assumes: pin active low
// Notes: one count per falling edge
`timescale 1ns/100ps
module sia_host_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // device pin
  input wire logic pciInterruptPin_n,
  // services taken
  output logic [7:0] irqCount
);
  logic pinSeen_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinSeen_q <= 1'b1;
      irqCount <= 8'h00;
    end else begin
      pinSeen_q <= pciInterruptPin_n;
      if (pinSeen_q && !pciInterruptPin_n) begin
        irqCount <= irqCount + 8'h01;
      end
    end
  end
endmodule : sia_host_model

// file: bench/test_status_interrupt_aggregator.sv
// Purpose: directed test of the status block
// Assumes: strobes one cycle, read data one cycle late
// Notes: host model counts interrupts
`timescale 1ns/100ps
module test_status_interrupt_aggregator;
  import sia_pkg::*;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  sia_addr_t regAddr = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  sia_word_t regWrData = 16'h0000;
  sia_word_t regRdData;
  sia_word_t rdv;
  logic [6:0] mEv = 7'h00;
  logic [7:0] dEv = 8'h00;
  logic [15:0] lEv = 16'h0000;
  logic [15:0] lTmo = 16'h0000;
  logic [15:0] lRst = 16'h0000;
  logic cfgMode = 1'b0;
  logic pinPci_n;
  logic pinLoc_n;
  logic [7:0] irqCount;
  int n_fail = 0;
  int cmp_count = 0;
  int mb[7] = '{0, 1, 2, 3, 4, 14, 15};
  sia_addr_t offs[6] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
  sia_status_top i_dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .rxFrameAlignChange(mEv[0]), .txFrameAlignChange(mEv[1]), .bitTesterStateChange(mEv[2]),
    .pciSystemError(mEv[3]), .pciParityError(mEv[4]), .localBusTimeoutError(mEv[5]),
    .localBusIrqSeen(mEv[6]), .rxChecksumError(dEv[0]), .rxAbortSeen(dEv[1]),
    .rxLengthViolation(dEv[2]), .rxFifoOverflow(dEv[3]), .largeFreeQueueRead(dEv[4]),
    .largeFreeQueueEmptyError(dEv[5]), .smallFreeQueueRead(dEv[6]),
    .smallFreeQueueEmptyError(dEv[7]), .portLoopCodeEvent(lEv), .loopSearchTimeout(lTmo),
    .loopDetectorReset(lRst), .localBusConfigMode(cfgMode), .pciInterruptPin_n(pinPci_n),
    .localInterruptPin_n(pinLoc_n));
  sia_host_model i_host (.core_clk(core_clk), .nrst(nrst), .pciInterruptPin_n(pinPci_n),
    .irqCount(irqCount));
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // =====
  // tasks
  task automatic chk(input sia_word_t seen, input sia_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input sia_addr_t a, input sia_word_t d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input sia_addr_t a);
    @(posedge core_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge core_clk);
    regRdEn <= 1'b0;
    #1 rdv = regRdData;
  endtask : rd
  task automatic rc(input sia_addr_t a, input sia_word_t exp);
    rd(a);
    chk(rdv, exp);
  endtask : rc
  task automatic clr();
    @(posedge core_clk);
    {mEv, dEv, lEv, lTmo} <= '0;
  endtask : clr
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic conclude();
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  // =====
  // sequence
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (offs[i]) rc(offs[i], 16'h0000);
    chk(pinPci_n, 1'b1);
    wr(8'h24, 16'hffff);
    wr(8'h2c, 16'hffff);
    wr(8'h34, 16'h0020);
    wr(8'h28, 16'hffff);
    cfgMode <= 1'b1;
    rc(8'h24, 16'hc01f);
    rc(8'h2c, 16'hfffc);
    rc(8'h34, 16'h0020);
    rc(8'h28, 16'h0000);
    rc(8'h40, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      dEv <= 8'(1 << i);
      clr();
      tick(1);
      chk(pinPci_n, 1'b0);
      chk(pinLoc_n, 1'b0);
      rc(8'h28, 16'(4 << i));
      tick(1);
      chk(pinPci_n, 1'b1);
      rc(8'h28, 16'h0000);
    end
    for (int i = 0; i < 7; i++) begin
      @(posedge core_clk);
      mEv <= 7'(1 << i);
      clr();
      tick(1);
      chk(pinPci_n, 1'b0);
      chk(pinLoc_n, i == 6);
      rc(8'h20, 16'(1 << mb[i]));
      tick(1);
    end
    wr(8'h24, 16'h0000);
    wr(8'h2c, 16'h0000);
    @(posedge core_clk);
    mEv <= 7'h01;
    dEv <= 8'h02;
    lEv <= 16'h0040;
    clr();
    tick(2);
    chk(pinPci_n, 1'b1);
    rc(8'h28, 16'h0008);
    rc(8'h30, 16'h0040);
    @(posedge core_clk);
    lEv <= 16'h0020;
    clr();
    tick(1);
    chk(pinPci_n, 1'b0);
    chk(pinLoc_n, 1'b0);
    rc(8'h30, 16'h0020);
    rc(8'h30, 16'h0000);
    @(posedge core_clk);
    lTmo <= 16'h0008;
    clr();
    rc(8'h30, 16'h0008);
    rc(8'h30, 16'h0008);
    @(posedge core_clk);
    lRst <= 16'h0008;
    rd(8'h30);
    rc(8'h30, 16'h0000);
    @(posedge core_clk);
    cfgMode <= 1'b0;
    tick(3);
    @(posedge core_clk);
    lEv <= 16'h0020;
    clr();
    tick(1);
    chk(pinPci_n, 1'b0);
    chk(pinLoc_n, 1'b1);
    rc(8'h30, 16'h0020);
    chk(16'(irqCount), 16'h0011);
    conclude();
  end
endmodule : test_status_interrupt_aggregator
